// ### rtl/sep_pkg.sv
// constants, types and helpers for the serial eeprom bus front end
package sep_pkg;

  // array geometry
  localparam int MEM_AW = 16;
  localparam int ID_AW = 7;
  localparam int LOCK_ADDR_BIT = 10;

  // instruction codes
  localparam logic [7:0] OP_WR_STAT = 8'h01;
  localparam logic [7:0] OP_WR_MEM = 8'h02;
  localparam logic [7:0] OP_RD_MEM = 8'h03;
  localparam logic [7:0] OP_CLR_WEL = 8'h04;
  localparam logic [7:0] OP_RD_STAT = 8'h05;
  localparam logic [7:0] OP_SET_WEL = 8'h06;
  localparam logic [7:0] OP_WR_ID = 8'h82;
  localparam logic [7:0] OP_RD_ID = 8'h83;

  // status byte field positions
  localparam int SR_WIP = 0;
  localparam int SR_WEL = 1;
  localparam int SR_BP_LO = 2;
  localparam int SR_BP_HI = 3;
  localparam int SR_SRWD = 7;

  // values after reset of the stored protection bits
  localparam logic BP_HI_RST = 1'b0;
  localparam logic BP_LO_RST = 1'b0;
  localparam logic SRWD_RST = 1'b0;
  localparam logic ID_LOCK_RST = 1'b0;

  // internal write cycle length in clk_sys cycles
  localparam logic [7:0] WRITE_BUSY_CYC = 8'h32;

  // pin index inside the synchroniser vector
  localparam int PIN_CLK = 0;
  localparam int PIN_CS = 1;
  localparam int PIN_MOSI = 2;
  localparam int PIN_HOLD = 3;
  localparam int PIN_WP = 4;
  localparam int PIN_N = 5;

  typedef enum logic [2:0] {
    ST_CMD = 3'b000,
    ST_ADDR_HI = 3'b001,
    ST_ADDR_LO = 3'b010,
    ST_RD_DATA = 3'b011,
    ST_WR_DATA = 3'b100,
    ST_SR_RD = 3'b101,
    ST_SR_WR = 3'b110,
    ST_WAIT = 3'b111
  } sep_state_type;

  // true when the address lies in the frozen area
  function automatic logic sep_protected(input logic hi, input logic lo,
                                         input logic [15:0] addr);
    logic res;
    res = 1'b0;
    unique case ({hi, lo})
      2'b00: res = 1'b0;
      2'b01: res = (addr[15:14] == 2'b11);
      2'b10: res = addr[15];
      2'b11: res = 1'b1;
    endcase
    return res;
  endfunction

endpackage

// ### rtl/sep_mem.sv
// byte-wide storage array with registered read data
`timescale 1ns/1ps
module sep_mem #(
  parameter int AW = 16
) (
  input wire logic clk_sys,
  input wire logic we,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic [AW-1:0] rdAddr,
  output logic [7:0] rdData
);

  logic [7:0] mem [0:(1<<AW)-1];

  // one write port, one registered read port
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end

endmodule

// ### rtl/sep_bus_interface.sv
// serial bus front end of the eeprom: pins, framing, shifting, protection
`timescale 1ns/1ps
// How it works
// - main array holds 65536 bytes, reached only over the serial pins
// - extra 128-byte id page, lockable for good to read-only
// - select high means deselected and data output not driven
// - deselected gives standby unless a write cycle runs; low is active
// - after reset nothing is decoded until a select falling edge
// - input bits are captured on serial clock rising edges
// - output bit changes on serial clock falling edges
// - all bytes in and out travel most significant bit first
// - first input bit is taken on first rising edge after select falls
// - first output bit driven on first falling edge after instruction and any address bytes
// - hold low pauses the transfer, which resumes where it stopped
// - while paused output is released and clock and input are ignored
// - with the guard set, write protect low freezes block protect bits and the guard
// - clock idle low or idle high both work, edges used identically
// - select going high during a pause resets the interface state
module sep_bus_interface
  import sep_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic spiClk,
  input wire logic csN,
  input wire logic mosi,
  input wire logic holdN,
  input wire logic wpN,
  output logic misoO,
  output logic misoOe,
  output logic standby
);

  logic [PIN_N-1:0] syncA_r;
  logic [PIN_N-1:0] syncB_r;
  logic clkPrev_r;
  logic csPrev_r;
  logic clkS, csS, mosiS, holdS, wpS;
  logic clkRise, clkFall, csFall, csRise;
  logic armed_r;
  logic paused_r;
  logic active;
  logic rise, fall;
  sep_state_type state_r;
  logic [2:0] bitCnt_r;
  logic [6:0] inSh_r;
  logic [7:0] rxByte;
  logic byteDone;
  logic [7:0] cmd_r;
  logic [15:0] addr_r;
  logic [2:0] outCnt_r;
  logic [7:0] outSh_r;
  logic outActive_r;
  logic misoO_r;
  logic wel_r, bpHi_r, bpLo_r, srwd_r, idLock_r;
  logic wrote_r;
  logic [7:0] busyCnt_r;
  logic wip;
  logic [7:0] statusByte;
  logic [7:0] outSrc;
  logic memWe_r, idWe_r;
  logic [15:0] wrAddr_r;
  logic [7:0] wrData_r;
  logic [7:0] memRd, idRd;
  logic srWritable;

  // two-stage synchronisers; stage A feeds stage B only
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      syncA_r <= '0;
      syncB_r <= '0;
    end else begin
      syncA_r <= {wpN, holdN, mosi, csN, spiClk};
      syncB_r <= syncA_r;
    end
  end

  assign clkS = syncB_r[PIN_CLK];
  assign csS = syncB_r[PIN_CS];
  assign mosiS = syncB_r[PIN_MOSI];
  assign holdS = syncB_r[PIN_HOLD];
  assign wpS = syncB_r[PIN_WP];

  // edge finders on the synchronised pins
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clkPrev_r <= 1'b0;
      csPrev_r <= 1'b0;
    end else begin
      clkPrev_r <= clkS;
      csPrev_r <= csS;
    end
  end

  // only edges matter, so idle level of the clock is irrelevant
  assign clkRise = clkS & ~clkPrev_r;
  assign clkFall = ~clkS & clkPrev_r;
  // reset leaves csPrev low, so a pin tied low never fakes an edge
  assign csFall = ~csS & csPrev_r;
  assign csRise = csS & ~csPrev_r;

  // power-up guard: decoding opens at the first real select fall
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      armed_r <= 1'b0;
    end else if (csFall) begin
      armed_r <= 1'b1;
    end
  end

  // pause entry and exit by hold only while the clock sits low; deselect ends a pause at any clock level
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      paused_r <= 1'b0;
    end else if (csS) begin
      paused_r <= 1'b0;
    end else if (!clkS) begin
      paused_r <= ~holdS;
    end
  end

  // clock edges during a pause are dropped, counters keep their place
  assign active = ~csS & armed_r & ~paused_r;
  assign rise = clkRise & active;
  assign fall = clkFall & active;
  assign rxByte = {inSh_r, mosiS};
  assign byteDone = rise & (bitCnt_r == 3'h7);
  assign wip = (busyCnt_r != 8'h00);

  // framing, instruction decode and address tracking
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= ST_CMD;
      bitCnt_r <= 3'h0;
      inSh_r <= 7'h00;
      cmd_r <= 8'h00;
      addr_r <= 16'h0000;
    end else if (csS || csFall) begin
      state_r <= ST_CMD;
      bitCnt_r <= 3'h0;
    end else if (rise) begin
      // first rise after the fall lands here with bitCnt at zero
      inSh_r <= rxByte[6:0];
      bitCnt_r <= bitCnt_r + 3'h1;
      if (bitCnt_r == 3'h7) begin
        unique case (state_r)
          ST_CMD: begin
            cmd_r <= rxByte;
            if (wip && rxByte != OP_RD_STAT) begin
              state_r <= ST_WAIT;
            end else begin
              unique case (rxByte)
                OP_RD_STAT: state_r <= ST_SR_RD;
                OP_WR_STAT: state_r <= ST_SR_WR;
                OP_RD_MEM, OP_WR_MEM, OP_RD_ID, OP_WR_ID: begin
                  state_r <= ST_ADDR_HI;
                end
                default: state_r <= ST_WAIT;
              endcase
            end
          end
          ST_ADDR_HI: begin
            addr_r[15:8] <= rxByte;
            state_r <= ST_ADDR_LO;
          end
          ST_ADDR_LO: begin
            addr_r[7:0] <= rxByte;
            if (cmd_r == OP_RD_MEM || cmd_r == OP_RD_ID) begin
              state_r <= ST_RD_DATA;
            end else begin
              state_r <= ST_WR_DATA;
            end
          end
          ST_WR_DATA: begin
            // writes wrap inside one 128-byte page
            addr_r <= {addr_r[15:7], addr_r[6:0] + 7'h01};
          end
          ST_SR_WR: state_r <= ST_WAIT;
          ST_RD_DATA, ST_SR_RD, ST_WAIT: state_r <= state_r;
          default: state_r <= ST_WAIT;
        endcase
      end
    end else if (fall && state_r == ST_RD_DATA && outCnt_r == 3'h0) begin
      // step past the byte just loaded; read data follows one cycle later
      if (cmd_r == OP_RD_ID) begin
        addr_r <= {addr_r[15:7], addr_r[6:0] + 7'h01};
      end else begin
        addr_r <= addr_r + 16'h0001;
      end
    end
  end

  // status byte as shifted out
  always_comb begin
    statusByte = 8'h00;
    statusByte[SR_WIP] = wip;
    statusByte[SR_WEL] = wel_r;
    statusByte[SR_BP_LO] = bpLo_r;
    statusByte[SR_BP_HI] = bpHi_r;
    statusByte[SR_SRWD] = srwd_r;
  end

  assign outSrc = (state_r == ST_SR_RD) ? statusByte :
                  (cmd_r == OP_RD_ID) ? idRd : memRd;

  // output shifter, advanced on falling edges only
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      outCnt_r <= 3'h0;
      outSh_r <= 8'h00;
      outActive_r <= 1'b0;
      misoO_r <= 1'b0;
    end else if (csS || csFall) begin
      outCnt_r <= 3'h0;
      outActive_r <= 1'b0;
    end else if (fall && (state_r == ST_RD_DATA || state_r == ST_SR_RD)) begin
      outActive_r <= 1'b1;
      outCnt_r <= outCnt_r + 3'h1;
      if (outCnt_r == 3'h0) begin
        misoO_r <= outSrc[7];
        outSh_r <= {outSrc[6:0], 1'b0};
      end else begin
        misoO_r <= outSh_r[7];
        outSh_r <= {outSh_r[6:0], 1'b0};
      end
    end
  end

  assign misoO = misoO_r;
  // released when deselected or paused; low enable means driving
  assign misoOe = ~(outActive_r & ~csS & ~paused_r);
  assign standby = csS & ~wip;

  // protect bits may change only when the guard allows it
  assign srWritable = wel_r & ~(srwd_r & ~wpS);

  // latch, protection bits, id lock and write bookkeeping
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wel_r <= 1'b0;
      bpHi_r <= BP_HI_RST;
      bpLo_r <= BP_LO_RST;
      srwd_r <= SRWD_RST;
      idLock_r <= ID_LOCK_RST;
      wrote_r <= 1'b0;
    end else if (csRise) begin
      // a finished write instruction consumes the latch
      if (wrote_r) begin
        wel_r <= 1'b0;
      end
      wrote_r <= 1'b0;
    end else if (byteDone) begin
      if (state_r == ST_CMD && !wip) begin
        if (rxByte == OP_SET_WEL) begin
          wel_r <= 1'b1;
        end else if (rxByte == OP_CLR_WEL) begin
          wel_r <= 1'b0;
        end
      end
      if (state_r == ST_SR_WR && srWritable) begin
        bpHi_r <= rxByte[SR_BP_HI];
        bpLo_r <= rxByte[SR_BP_LO];
        srwd_r <= rxByte[SR_SRWD];
        wrote_r <= 1'b1;
      end
      if (state_r == ST_WR_DATA && wel_r) begin
        wrote_r <= 1'b1;
        if (cmd_r == OP_WR_ID && addr_r[LOCK_ADDR_BIT] && !idLock_r) begin
          idLock_r <= 1'b1;
        end
      end
    end
  end

  // internal write cycle timer started by deselect after a write
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busyCnt_r <= 8'h00;
    end else if (csRise && wrote_r) begin
      busyCnt_r <= WRITE_BUSY_CYC;
    end else if (wip) begin
      busyCnt_r <= busyCnt_r - 8'h01;
    end
  end

  // byte write strobes, gated by latch, protected area and id lock
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      memWe_r <= 1'b0;
      idWe_r <= 1'b0;
      wrAddr_r <= 16'h0000;
      wrData_r <= 8'h00;
    end else begin
      memWe_r <= byteDone && state_r == ST_WR_DATA && wel_r &&
                 cmd_r == OP_WR_MEM &&
                 !sep_protected(bpHi_r, bpLo_r, addr_r);
      idWe_r <= byteDone && state_r == ST_WR_DATA && wel_r &&
                cmd_r == OP_WR_ID && !idLock_r &&
                !addr_r[LOCK_ADDR_BIT];
      wrAddr_r <= addr_r;
      wrData_r <= rxByte;
    end
  end

  // main array, only reachable through the shifters above
  sep_mem #(.AW(MEM_AW)) u_array (
    .clk_sys(clk_sys),
    .we(memWe_r),
    .wrAddr(wrAddr_r),
    .wrData(wrData_r),
    .rdAddr(addr_r),
    .rdData(memRd)
  );

  // id page, separate so the lock cannot touch the main array
  sep_mem #(.AW(ID_AW)) u_id_page (
    .clk_sys(clk_sys),
    .we(idWe_r),
    .wrAddr(wrAddr_r[ID_AW-1:0]),
    .wrData(wrData_r),
    .rdAddr(addr_r[ID_AW-1:0]),
    .rdData(idRd)
  );

  a_deselect_hiz:
  assert property (@(posedge clk_sys) disable iff (rst) csS |-> misoOe)
    else $error("output driven while deselected");

  a_write_busy:
  assert property (@(posedge clk_sys) disable iff (rst)
    (csRise && wrote_r) |=> (wip && !standby)[*8])
    else $error("no write cycle after write instruction");

  a_unarmed_idle:
  assert property (@(posedge clk_sys) disable iff (rst)
    !armed_r |-> (state_r == ST_CMD && bitCnt_r == 3'h0 && misoOe))
    else $error("activity before first select fall");

  a_rise_counts:
  assert property (@(posedge clk_sys) disable iff (rst)
    (rise && !csS) |=> csS || bitCnt_r == $past(bitCnt_r) + 3'h1)
    else $error("rising edge did not advance bit count");

  a_out_on_fall:
  assert property (@(posedge clk_sys) disable iff (rst)
    $changed(misoO) |-> $past(fall))
    else $error("output changed away from a falling edge");

  a_msb_first:
  assert property (@(posedge clk_sys) disable iff (rst)
    (fall && state_r == ST_SR_RD && outCnt_r == 3'h0)
      |=> misoO == $past(statusByte[SR_SRWD]))
    else $error("status byte not sent msb first");

  a_hold_hiz:
  assert property (@(posedge clk_sys) disable iff (rst)
    paused_r |-> misoOe)
    else $error("output driven during pause");

  a_hold_freeze:
  assert property (@(posedge clk_sys) disable iff (rst)
    (paused_r && !csS) |=> csS || (bitCnt_r == $past(bitCnt_r) &&
      state_r == $past(state_r) && outCnt_r == $past(outCnt_r)))
    else $error("transfer moved during pause");

  a_protect_frozen:
  assert property (@(posedge clk_sys) disable iff (rst)
    (srwd_r && !wpS) |=> $stable({bpHi_r, bpLo_r, srwd_r}))
    else $error("protect bits changed while frozen");

  a_no_prot_write:
  assert property (@(posedge clk_sys) disable iff (rst)
    memWe_r |-> !sep_protected(bpHi_r, bpLo_r, wrAddr_r))
    else $error("write into protected area");

  a_deselect_reset:
  assert property (@(posedge clk_sys) disable iff (rst)
    (csS && $past(paused_r)) |=> (state_r == ST_CMD && !paused_r))
    else $error("deselect in pause did not reset");

  a_fall_restart:
  assert property (@(posedge clk_sys) disable iff (rst)
    csFall |=> (bitCnt_r == 3'h0 && outCnt_r == 3'h0 && state_r == ST_CMD))
    else $error("select fall did not restart counters");

endmodule

// ### verif/sep_spi_master.sv
// spi bus master model that drives the eeprom pins
`timescale 1ns/1ps
module sep_spi_master (
  input wire logic clk_sys,
  input wire logic misoLine,
  output logic spiClk,
  output logic csN,
  output logic mosi,
  output logic holdN,
  output logic wpN
);
  logic cpol = 1'b0;

  // select starts low so that an unarmed start can be shown
  initial begin
    spiClk = 1'b0;
    csN = 1'b0;
    mosi = 1'b0;
    holdN = 1'b1;
    wpN = 1'b1;
  end

  // half serial period, four system cycles
  task automatic hp();
    repeat (4) @(negedge clk_sys);
  endtask

  // only this one device is ever selected on the line
  task automatic sel();
    hp();
    csN = 1'b0;
    hp();
  endtask

  // clock back to idle level before select rises
  task automatic desel();
    hp();
    spiClk = cpol;
    hp();
    csN = 1'b1;
    hp();
  endtask

  // clock low, data out, rise, sample late in the high phase
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      spiClk = 1'b0;
      mosi = tx[i];
      hp();
      spiClk = 1'b1;
      hp();
      rx[i] = misoLine;
    end
  endtask

  // hold moves only with the clock low; junk clocks while paused
  task automatic pause(input logic on);
    spiClk = 1'b0;
    hp();
    holdN = ~on;
    hp();
    if (on) begin
      repeat (3) begin
        spiClk = 1'b1;
        mosi = ~mosi;
        hp();
        spiClk = 1'b0;
        hp();
      end
    end
  endtask

  // idle level of the clock changes only while deselected
  task automatic mode(input logic p);
    cpol = p;
    spiClk = p;
    hp();
  endtask

  // protect pin moves only between instructions
  task automatic wp(input logic v);
    wpN = v;
    hp();
  endtask
endmodule

// ### verif/sep_bus_interface_tb.sv
// self-checking bench for the serial eeprom bus front end
`timescale 1ns/1ps
module sep_bus_interface_tb;
  import sep_pkg::*;
  logic clk_sys;
  logic rst;
  logic spiClk, csN, mosi, holdN, wpN, misoO, misoOe, standby;
  logic misoLine;
  logic relTog = 1'b0;
  logic oeSeen = 1'b0;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;

  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    forever #50 clk_sys = ~clk_sys;
  end

  // a released line shows a changing pattern, not the last bit
  assign misoLine = (misoOe === 1'b0) ? misoO : relTog;

  // pattern, output-enable watch and hang limit
  always @(posedge clk_sys) begin
    relTog <= ~relTog;
    cycles <= cycles + 1;
    if (misoOe === 1'b0) oeSeen <= 1'b1;
    if (cycles == 40000) begin
      errors++;
      tally_and_finish();
    end
  end

  sep_bus_interface dut (.clk_sys(clk_sys), .rst(rst), .spiClk(spiClk),
    .csN(csN), .mosi(mosi), .holdN(holdN), .wpN(wpN), .misoO(misoO),
    .misoOe(misoOe), .standby(standby));

  sep_spi_master master (.clk_sys(clk_sys), .misoLine(misoLine),
    .spiClk(spiClk), .csN(csN), .mosi(mosi), .holdN(holdN), .wpN(wpN));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic cmd(input logic [7:0] op);
    logic [7:0] r;
    master.sel();
    master.xfer(op, r);
    master.desel();
  endtask

  task automatic rd_stat(output logic [7:0] s);
    logic [7:0] r;
    master.sel();
    master.xfer(OP_RD_STAT, r);
    master.xfer(8'h00, s);
    master.desel();
  endtask

  // bounded poll of the busy bit
  task automatic wait_idle();
    logic [7:0] s;
    s = 8'h01;
    for (int i = 0; i < 20 && s[SR_WIP] !== 1'b0; i++) rd_stat(s);
    chk({7'h00, s[SR_WIP]}, 8'h00);
  endtask

  // latch set, then status or memory write, then wait for idle
  task automatic wr(input logic [7:0] op, input logic [15:0] a,
                    input logic [7:0] d, input logic busy);
    logic [7:0] r;
    cmd(OP_SET_WEL);
    master.sel();
    master.xfer(op, r);
    if (op != OP_WR_STAT) begin
      master.xfer(a[15:8], r);
      master.xfer(a[7:0], r);
    end
    master.xfer(d, r);
    master.desel();
    if (busy) begin
      repeat (4) @(negedge clk_sys);
      chk({7'h00, standby}, 8'h00);
    end
    wait_idle();
  endtask

  task automatic rd2(input logic [15:0] a, output logic [15:0] q);
    logic [7:0] r;
    master.sel();
    master.xfer(OP_RD_MEM, r);
    master.xfer(a[15:8], r);
    master.xfer(a[7:0], r);
    master.xfer(8'h00, q[15:8]);
    master.xfer(8'h00, q[7:0]);
    master.desel();
  endtask

  // select low straight out of reset must not arm the device
  task automatic s_unarmed();
    logic [7:0] r;
    oeSeen = 1'b0;
    master.xfer(OP_RD_STAT, r);
    master.xfer(8'h00, r);
    chk({7'h00, oeSeen}, 8'h00);
    master.desel();
    repeat (4) @(negedge clk_sys);
    chk({7'h00, standby}, 8'h01);
    chk({7'h00, misoOe}, 8'h01);
  endtask

  // top byte and byte zero, read across the address wrap
  task automatic s_rw(input logic p);
    logic [15:0] q;
    master.mode(p);
    rd2(16'hffff, q);
    chk(q[15:8], 8'ha5);
    chk(q[7:0], 8'h3c);
    master.mode(1'b0);
  endtask

  // whole array protected, then protect bits frozen by the pin
  task automatic s_prot();
    logic [15:0] q;
    logic [7:0] s;
    wr(OP_WR_STAT, 16'h0000, 8'h8c, 1'b0);
    wr(OP_WR_MEM, 16'h0000, 8'h77, 1'b0);
    rd2(16'hffff, q);
    chk(q[7:0], 8'h3c);
    master.wp(1'b0);
    wr(OP_WR_STAT, 16'h0000, 8'h00, 1'b0);
    rd_stat(s);
    chk(s & 8'h8c, 8'h8c);
    master.wp(1'b1);
    wr(OP_WR_STAT, 16'h0000, 8'h00, 1'b0);
    rd_stat(s);
    chk(s, 8'h00);
  endtask

  // pause mid read, resume, then abort a second pause by deselect
  task automatic s_hold();
    logic [7:0] r;
    master.sel();
    master.xfer(OP_RD_MEM, r);
    master.xfer(8'hff, r);
    master.xfer(8'hff, r);
    master.pause(1'b1);
    chk({7'h00, misoOe}, 8'h01);
    master.pause(1'b0);
    master.xfer(8'h00, r);
    chk(r, 8'ha5);
    master.pause(1'b1);
    master.desel();
    master.pause(1'b0);
    rd_stat(r);
    chk(r, 8'h00);
  endtask

  // id page write, read back, lock, refused write; latch clear opcode
  task automatic s_id();
    logic [7:0] r;
    logic [7:0] s;
    wr(OP_WR_ID, 16'h0005, 8'h5a, 1'b0);
    master.sel();
    master.xfer(OP_RD_ID, r);
    master.xfer(8'h00, r);
    master.xfer(8'h05, r);
    master.xfer(8'h00, r);
    master.desel();
    chk(r, 8'h5a);
    wr(OP_WR_ID, 16'h0400, 8'h00, 1'b0);
    wr(OP_WR_ID, 16'h0005, 8'h11, 1'b0);
    master.sel();
    master.xfer(OP_RD_ID, r);
    master.xfer(8'h00, r);
    master.xfer(8'h05, r);
    master.xfer(8'h00, r);
    master.desel();
    chk(r, 8'h5a);
    cmd(OP_SET_WEL);
    cmd(OP_CLR_WEL);
    rd_stat(s);
    chk(s, 8'h00);
  endtask

  task automatic tally_and_finish();
    if (errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // reset for 16 cycles, then the scenarios in order
  initial begin
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    s_unarmed();
    wr(OP_WR_MEM, 16'hffff, 8'ha5, 1'b1);
    wr(OP_WR_MEM, 16'h0000, 8'h3c, 1'b1);
    s_rw(1'b0);
    s_rw(1'b1);
    s_prot();
    s_hold();
    s_id();
    tally_and_finish();
  end
endmodule
